// File: dv/async_comm_element_sva.sv
// line direction and frame timing assertions for the serial port
`timescale 1ns/100ps
`include "uart_dir_defines.vh"
module dir_line_checker
(
  input wire       CLK,
  input wire       RST,
  input wire [2:0] ADDR,
  input wire       WR,
  input wire       TXD,
  input wire       DRV_EN,
  input wire       RCV_EN
);
  logic [15:0] quiet;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // idle-high cycles while driving; shortest legal hold is stop plus 5N1
  always @(posedge CLK)
    if (RST || !TXD || !DRV_EN)
      quiet <= 16'h0000;
    else if (quiet != 16'hffff)
      quiet <= quiet + 16'h0001;
  chk_drv_rise: assert property (
    (WR && ADDR == `A_DATA && !DRV_EN) |-> ##2 DRV_EN)
    else $error("driver not enabled after queued byte");
  chk_tx_order: assert property ($rose(DRV_EN) |-> TXD)
    else $error("line moved before driver enable");
  chk_drv_hold: assert property (
    $fell(DRV_EN) |-> quiet >= 16'h0078)
    else $error("driver dropped before character hold");
  chk_drv_busy: assert property (!TXD |-> DRV_EN)
    else $error("line low without driver enable");
  chk_drv_steady: assert property (
    $rose(DRV_EN) |-> DRV_EN [*8] ##1 DRV_EN [*8])
    else $error("driver enable too short");
  chk_rcv_half: assert property (!RCV_EN |-> DRV_EN)
    else $error("receiver off while not sending");
  chk_rcv_tracks: assert property (
    (!RCV_EN && $past(RCV_EN) && !$past(WR)) |-> $rose(DRV_EN))
    else $error("receiver off without driver start");
  chk_start_len: assert property (
    $fell(TXD) |-> !TXD [*8] ##1 !TXD [*8])
    else $error("low line run shorter than a bit");
  chk_stop_len: assert property (
    $rose(TXD) |-> TXD [*8] ##1 TXD [*8])
    else $error("high line run shorter than a bit");
endmodule
bind async_comm_element dir_line_checker u_chk
(
  .CLK(CLK),
  .RST(RST),
  .ADDR(ADDR),
  .WR(WR),
  .TXD(TXD),
  .DRV_EN(DRV_EN),
  .RCV_EN(RCV_EN)
);

// File: dv/async_comm_element_test.sv
// self-checking bench for the serial port with line direction control
`timescale 1ns/100ps
`include "uart_dir_defines.vh"
module async_comm_element_test;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic [2:0]  ADDR = 3'h0;
  logic [7:0]  WDATA = 8'h00;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        RANGE_4X = 1'b1;
  logic [31:0] bitc = 32'h10;
  logic [3:0]  nbits = 4'h8;
  logic        par_en = 1'b0;
  wire  [7:0]  RDATA;
  wire         RXD;
  wire         TXD;
  wire         DRV_EN;
  wire         RCV_EN;
  integer      n_errors;
  integer      n_checks;
  integer      i;
  integer      j;
  integer      k;
  integer      f;
  integer      cnt;
  integer      lo;
  logic [15:0] e;
  logic [7:0]  d;
  logic [7:0]  v;
  logic [8:0]  x;
  logic [7:0]  rtab [1:7] = '{8'h03, 8'h01, 8'h00, 8'h84, 8'h01, 8'h00,
                              8'h00};
  // line, divisor, range: covers every length, parity and stop choice
  logic [15:0] tab [0:5] = '{16'h0011, 16'h0411, 16'h0921, 16'h1a10,
                             16'h1f31, 16'h0320};
  always #50 CLK = ~CLK;
  async_comm_element dut
  (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .RANGE_4X(RANGE_4X), .RXD(RXD), .TXD(TXD),
    .DRV_EN(DRV_EN), .RCV_EN(RCV_EN)
  );
  line_node node
  (
    .clk(CLK), .txd(TXD), .drv_en(DRV_EN), .bitc(bitc), .nbits(nbits),
    .par_en(par_en), .rxd(RXD)
  );
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] dv);
    begin
      ADDR <= a;
      WDATA <= dv;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
      // let an edge pass so a following write never re-raises WR at once
      @(posedge CLK);
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [2:0] a, output [7:0] dv);
    begin
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      @(negedge CLK);
      dv = RDATA;
      @(posedge CLK);
    end
  endtask
  task complete_run;
    begin
      if (n_errors == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial
  begin
    repeat (40000) @(posedge CLK);
    n_errors = n_errors + 1;
    complete_run;
  end
  initial
  begin
    n_errors = 0;
    n_checks = 0;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    chk({TXD, DRV_EN, RCV_EN}, 3'b101);
    wr(3'h7, 8'hff);
    for (i = 1; i < 8; i = i + 1)
    begin
      rd(i[2:0], v);
      chk(v, rtab[i]);
    end
    for (i = 0; i < 6; i = i + 1)
    begin
      e = tab[i];
      k = (e[0] ? 1 : 4) * e[7:4];
      f = e[9:8] + 5;
      RANGE_4X <= e[0];
      nbits <= f[3:0];
      par_en <= e[11];
      bitc <= 16 * k;
      wr(`A_DIV_LO, {4'h0, e[7:4]});
      wr(`A_LINE, e[15:8]);
      // range input crosses two flops before it counts
      repeat (3) @(posedge CLK);
      lo = 2 * k * (16 * (1 + f + e[11]) + (e[10] ? (f == 5 ? 24 : 32) : 16));
      d = 8'h5a ^ e[15:8];
      wr(`A_DATA, d);
      cnt = 0;
      for (j = 0; j < 9000 && (cnt == 0 || DRV_EN); j = j + 1)
      begin
        @(negedge CLK);
        if (DRV_EN === 1'b1)
          cnt = cnt + 1;
      end
      chk(cnt >= lo && cnt <= lo + 3 * k + 2, 1);
      x = {1'b0, d & ((8'h01 << f) - 8'h01)};
      if (e[11])
        x[f] = ~^x ^ e[12];
      chk(node.got.pop_front(), x);
      @(posedge CLK);
    end
    wr(`A_MODE, 8'h00);
    RANGE_4X <= 1'b1;
    nbits <= 4'h8;
    par_en <= 1'b0;
    bitc <= 32'h10;
    wr(`A_DIV_LO, 8'h01);
    wr(`A_LINE, 8'h03);
    repeat (3) @(posedge CLK);
    // one byte in the shifter, sixteen queued, the last one dropped
    for (i = 0; i < 18; i = i + 1)
      wr(`A_DATA, i[7:0]);
    rd(`A_STATUS, v);
    chk(v[`ST_TX_FULL], 1);
    chk(RCV_EN, 1);
    for (j = 0; j < 20000 && DRV_EN !== 1'b0; j = j + 1)
      @(posedge CLK);
    chk(node.got.size(), 17);
    for (i = 0; i < 17; i = i + 1)
      chk(node.got.pop_front(), i);
    wr(`A_LINE, 8'h1b);
    for (i = 0; i < 2; i = i + 1)
    begin
      node.send({i[0], 8'ha5}, 9);
      rd(`A_STATUS, v);
      chk(v, i ? 8'h8d : 8'h85);
      rd(`A_DATA, v);
      chk(v, 8'ha5);
    end
    rd(`A_STATUS, v);
    chk(v, 8'h84);
    complete_run;
  end
endmodule

// File: dv/line_node.sv
// remote line node: decodes frames from the port and sends frames back
`timescale 1ns/100ps
module line_node
(
  input  wire        clk,
  input  wire        txd,
  input  wire        drv_en,
  input  wire [31:0] bitc,
  input  wire [3:0]  nbits,
  input  wire        par_en,
  output reg         rxd
);
  logic [8:0] got [$];
  logic [8:0] w;
  integer     i;
  // biased pair rests at mark when nobody drives
  initial rxd = 1'b1;
  // mid-bit sampling, only of frames the port really drives
  always @(negedge txd)
    if (drv_en)
    begin
      w = 9'h000;
      repeat (bitc / 2) @(posedge clk);
      for (i = 0; i < nbits + par_en; i = i + 1)
      begin
        repeat (bitc) @(posedge clk);
        w[i] = txd;
      end
      got.push_back(w);
    end
  // never talks over the port in half duplex
  task send(input [8:0] v, input integer n);
    integer k;
    begin
      while (drv_en)
        @(posedge clk);
      rxd <= 1'b0;
      repeat (bitc) @(posedge clk);
      for (k = 0; k < n; k = k + 1)
      begin
        rxd <= v[k];
        repeat (bitc) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (bitc) @(posedge clk);
    end
  endtask
endmodule

// File: rtl/async_comm_element.v
// buffered serial port with automatic line direction control
//
// Notes on behaviour
// - driver enable rises once transmit data queued
// - driver held one character after last shifted
// - in half duplex, receiver off while sending, back after hold
// - hold time follows programmed baud divisor
// - five to eight data bits per frame
// - even, odd or no parity, checked
// - stop of one, one-and-half, two bits
// - sixteen-byte queues for transmit and receive
// - static range input selects 1x or 4x
// - bit timing generated from programmed divisor
// - full-duplex and half-duplex operation supported
// - half duplex lets one direction at once
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "uart_dir_defines.vh"
module async_comm_element
#(
  parameter QUEUE_LOG2 = 4
)
(
  input  wire       CLK,
  input  wire       RST,
  input  wire [2:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  input  wire       RANGE_4X,
  input  wire       RXD,
  output reg        TXD,
  output wire       DRV_EN,
  output wire       RCV_EN
);
  localparam T_IDLE = 3'h0;
  localparam T_LOAD = 3'h1;
  localparam T_STRT = 3'h2;
  localparam T_DATA = 3'h3;
  localparam T_PAR  = 3'h4;
  localparam T_STOP = 3'h5;
  localparam R_IDLE = 2'h0;
  localparam R_STRT = 2'h1;
  localparam R_BITS = 2'h2;
  localparam D_QUIET = 2'h0;
  localparam D_SEND  = 2'h1;
  localparam D_HOLD  = 2'h2;

  reg  [7:0]  line_ctl;
  reg  [15:0] divisor;
  reg  [7:0]  mode;
  reg         par_err;
  reg         frm_err;
  reg         overrun;
  reg  [2:0]  rd_sel;
  reg  [1:0]  range_sync;
  reg  [1:0]  rxd_sync;
  reg  [2:0]  pre_cnt;
  reg  [15:0] div_cnt;
  reg         tick;
  reg  [2:0]  tx_state;
  reg  [4:0]  tx_ticks;
  reg  [3:0]  tx_bit;
  reg  [7:0]  tx_shift;
  reg         tx_par;
  reg  [1:0]  rx_state;
  reg  [4:0]  rx_ticks;
  reg  [3:0]  rx_bit;
  reg  [7:0]  rx_shift;
  reg         rx_par;
  reg  [1:0]  dir;
  reg  [8:0]  hold_cnt;
  reg         rx_push;
  reg         rx_bad_par;
  reg         rx_bad_stop;
  reg  [7:0]  status_word;
  wire [3:0]  data_bits;
  wire [5:0]  stop_ticks;
  wire [8:0]  char_ticks;
  wire [2:0]  prescale;
  wire [15:0] div_eff;
  wire        tx_full;
  wire        tx_empty;
  wire [7:0]  tx_head;
  wire        rx_full;
  wire        rx_empty;
  wire [7:0]  rx_head;
  wire        tx_pop;
  wire        rx_pop;
  wire        rx_line;
  wire        half;
  wire        tx_busy;
  wire        rx_sample;

  // frame format decoded once, shared by transmitter, receiver, hold
  assign data_bits  = {2'b00, line_ctl[`LINE_LEN_HI:`LINE_LEN_LO]} +
                      4'h5;
  assign stop_ticks = !line_ctl[`LINE_STOP] ? `STOP_ONE :
                      (data_bits == 4'h5) ? `STOP_MID : `STOP_TWO;
  // one character in sixteenth-bit ticks; scales with divisor
  assign char_ticks = {1'b0, data_bits, 4'h0} + 9'h010 +
                      (line_ctl[`LINE_PAR_EN] ? 9'h010 : 9'h000) +
                      {3'b000, stop_ticks};
  assign half       = mode[`MODE_HALF];

  // one-bit result so the parity compare is never widened against
  // an inverted even-select bit
  function odd_of;
    input [7:0] bits;
    input [3:0] len;
    reg   [7:0] mask;
    begin
      mask   = 8'hff >> (4'h8 - len);
      odd_of = ^(bits & mask);
    end
  endfunction

  always @(posedge CLK)
  begin
    if (RST)
    begin
      range_sync <= 2'b00;
      rxd_sync   <= 2'b11;
    end
    else
    begin
      range_sync <= {range_sync[0], RANGE_4X};
      rxd_sync   <= {rxd_sync[0], RXD};
    end
  end

  // 4x range drops the prescaler, so the same divisor runs four times
  // faster from one oscillator
  assign prescale = range_sync[1] ? `PRESCALE_4X : `PRESCALE_1X;
  assign div_eff  = (divisor == 16'h0000) ? 16'h0001 : divisor;

  always @(posedge CLK)
  begin
    if (RST)
    begin
      pre_cnt <= 3'h0;
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (pre_cnt >= prescale - 3'h1)
      begin
        pre_cnt <= 3'h0;
        if (div_cnt >= div_eff - 16'h0001)
        begin
          div_cnt <= 16'h0000;
          tick    <= 1'b1;
        end
        else
          div_cnt <= div_cnt + 16'h0001;
      end
      else
        pre_cnt <= pre_cnt + 3'h1;
    end
  end

  byte_queue
  #(
    .WIDTH      (8),
    .DEPTH_LOG2 (QUEUE_LOG2)
  )
  tx_queue
  (
    .clk       (CLK),
    .rst       (RST),
    .push      (WR && ADDR == `A_DATA),
    .push_data (WDATA),
    .full      (tx_full),
    .pop       (tx_pop),
    .pop_data  (tx_head),
    .empty     (tx_empty)
  );

  byte_queue
  #(
    .WIDTH      (8),
    .DEPTH_LOG2 (QUEUE_LOG2)
  )
  rx_queue
  (
    .clk       (CLK),
    .rst       (RST),
    .push      (rx_push),
    .push_data (rx_shift),
    .full      (rx_full),
    .pop       (rx_pop),
    .pop_data  (rx_head),
    .empty     (rx_empty)
  );

  // transmitter only starts once the driver is already on the line
  assign tx_pop  = (tx_state == T_IDLE) && !tx_empty && (dir == D_SEND);
  assign tx_busy = (tx_state != T_IDLE) || !tx_empty;
  assign rx_pop  = RD && (ADDR == `A_DATA);

  always @(posedge CLK)
  begin
    if (RST)
    begin
      tx_state <= T_IDLE;
      tx_ticks <= 5'h00;
      tx_bit   <= 4'h0;
      tx_shift <= 8'h00;
      tx_par   <= 1'b0;
      TXD      <= 1'b1;
    end
    else
    begin
      case (tx_state)
        T_IDLE:
        begin
          TXD <= 1'b1;
          if (tx_pop)
            tx_state <= T_LOAD;
        end
        T_LOAD:
        begin
          tx_shift <= tx_head;
          tx_par   <= odd_of(tx_head, data_bits) ^
                      ~line_ctl[`LINE_EVEN];
          tx_ticks <= 5'h00;
          tx_bit   <= 4'h0;
          if (tick)
          begin
            TXD      <= 1'b0;
            tx_state <= T_STRT;
          end
        end
        T_STRT, T_DATA, T_PAR:
        begin
          if (tick)
          begin
            if (tx_ticks == `OVERSAMPLE - 5'h01)
            begin
              tx_ticks <= 5'h00;
              if (tx_state != T_DATA)
                tx_bit <= 4'h0;
              else
                tx_bit <= tx_bit + 4'h1;
              if (tx_state == T_STRT ||
                  (tx_state == T_DATA && tx_bit < data_bits - 4'h1))
              begin
                TXD      <= tx_shift[0];
                tx_shift <= {1'b0, tx_shift[7:1]};
                tx_state <= T_DATA;
              end
              else if (tx_state == T_DATA && line_ctl[`LINE_PAR_EN])
              begin
                TXD      <= tx_par;
                tx_state <= T_PAR;
              end
              else
              begin
                TXD      <= 1'b1;
                tx_state <= T_STOP;
              end
            end
            else
              tx_ticks <= tx_ticks + 5'h01;
          end
        end
        T_STOP:
        begin
          if (tick)
          begin
            if ({1'b0, tx_ticks} == stop_ticks - 6'h01 ||
                tx_ticks == 5'h1f)
            begin
              tx_ticks <= 5'h00;
              tx_state <= T_IDLE;
            end
            else
              tx_ticks <= tx_ticks + 5'h01;
          end
        end
        default:
          tx_state <= T_IDLE;
      endcase
    end
  end

  // line direction: quiet, sending, then one-character hold
  always @(posedge CLK)
  begin
    if (RST)
    begin
      dir      <= D_QUIET;
      hold_cnt <= 9'h000;
    end
    else
    begin
      case (dir)
        D_QUIET:
          if (!tx_empty)
            dir <= D_SEND;
        D_SEND:
          if (!tx_busy)
          begin
            hold_cnt <= char_ticks;
            dir      <= D_HOLD;
          end
        D_HOLD:
        begin
          if (!tx_empty)
            dir <= D_SEND;
          else if (hold_cnt == 9'h000)
            dir <= D_QUIET;
          else if (tick)
            hold_cnt <= hold_cnt - 9'h001;
        end
        default:
          dir <= D_QUIET;
      endcase
    end
  end

  assign DRV_EN = (dir != D_QUIET);
  // full duplex keeps both pairs live; half duplex turns the line
  // round so only one direction flows
  assign RCV_EN = !half || (dir == D_QUIET);
  // a disabled receiver sees an idle line, so own echo is never framed
  assign rx_line = RCV_EN ? rxd_sync[1] : 1'b1;
  assign rx_sample = tick && (rx_ticks == `OVERSAMPLE - 5'h01);

  always @(posedge CLK)
  begin
    if (RST)
    begin
      rx_state    <= R_IDLE;
      rx_ticks    <= 5'h00;
      rx_bit      <= 4'h0;
      rx_shift    <= 8'h00;
      rx_par      <= 1'b0;
      rx_push     <= 1'b0;
      rx_bad_par  <= 1'b0;
      rx_bad_stop <= 1'b0;
    end
    else
    begin
      rx_push     <= 1'b0;
      rx_bad_par  <= 1'b0;
      rx_bad_stop <= 1'b0;
      case (rx_state)
        R_IDLE:
        begin
          rx_ticks <= 5'h00;
          rx_bit   <= 4'h0;
          rx_shift <= 8'h00;
          if (!rx_line)
            rx_state <= R_STRT;
        end
        R_STRT:
        begin
          if (tick)
          begin
            if (rx_ticks == `HALF_BIT - 5'h01)
            begin
              rx_ticks <= 5'h00;
              rx_state <= rx_line ? R_IDLE : R_BITS;
            end
            else
              rx_ticks <= rx_ticks + 5'h01;
          end
        end
        R_BITS:
        begin
          if (tick)
            rx_ticks <= rx_sample ? 5'h00 : rx_ticks + 5'h01;
          if (rx_sample)
          begin
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit < data_bits)
              rx_shift <= rx_shift |
                          ({7'h00, rx_line} << rx_bit[2:0]);
            else if (rx_bit == data_bits && line_ctl[`LINE_PAR_EN])
              rx_par <= rx_line;
            else
            begin
              // stop sampled once; remaining stop time is idle wait
              rx_push     <= 1'b1;
              rx_bad_stop <= !rx_line;
              rx_bad_par  <= line_ctl[`LINE_PAR_EN] &&
                             (rx_par != (odd_of(rx_shift, data_bits) ^
                              ~line_ctl[`LINE_EVEN]));
              rx_state    <= R_IDLE;
            end
          end
        end
        default:
          rx_state <= R_IDLE;
      endcase
    end
  end

  // register file; sticky errors clear on status read, set wins
  always @(posedge CLK)
  begin
    if (RST)
    begin
      line_ctl <= `LINE_RESET;
      divisor  <= `DIV_RESET;
      mode     <= `MODE_RESET;
      par_err  <= 1'b0;
      frm_err  <= 1'b0;
      overrun  <= 1'b0;
      rd_sel   <= 3'h7;
    end
    else
    begin
      rd_sel <= RD ? ADDR : 3'h7;
      if (WR && ADDR == `A_LINE)
        line_ctl <= {3'b000, WDATA[4:0]};
      if (WR && ADDR == `A_DIV_LO)
        divisor[7:0] <= WDATA;
      if (WR && ADDR == `A_DIV_HI)
        divisor[15:8] <= WDATA;
      if (WR && ADDR == `A_MODE)
        mode <= {7'h00, WDATA[`MODE_HALF]};
      if (RD && ADDR == `A_STATUS)
      begin
        par_err <= 1'b0;
        frm_err <= 1'b0;
        overrun <= 1'b0;
      end
      if (rx_bad_par)
        par_err <= 1'b1;
      if (rx_bad_stop)
        frm_err <= 1'b1;
      if (rx_push && rx_full)
        overrun <= 1'b1;
    end
  end

  always @*
  begin
    case (rd_sel)
      `A_DATA:   RDATA = rx_head;
      `A_LINE:   RDATA = line_ctl;
      `A_DIV_LO: RDATA = divisor[7:0];
      `A_DIV_HI: RDATA = divisor[15:8];
      `A_STATUS: RDATA = status_word;
      `A_MODE:   RDATA = mode;
      default:   RDATA = 8'h00;
    endcase
  end

  always @(posedge CLK)
  begin
    if (RST)
      status_word <= 8'h00;
    else
    begin
      status_word                <= 8'h00;
      status_word[`ST_RX_AVAIL] <= !rx_empty;
      status_word[`ST_TX_FULL]  <= tx_full;
      status_word[`ST_TX_IDLE]  <= !tx_busy;
      status_word[`ST_PAR_ERR]  <= par_err;
      status_word[`ST_FRM_ERR]  <= frm_err;
      status_word[`ST_OVERRUN]  <= overrun;
      status_word[`ST_DRV_EN]   <= DRV_EN;
      status_word[`ST_RCV_EN]   <= RCV_EN;
    end
  end
endmodule

// File: rtl/byte_queue.v
// small first-in first-out store with registered read data
`timescale 1ns/100ps
module byte_queue
#(
  parameter WIDTH      = 8,
  parameter DEPTH_LOG2 = 4
)
(
  input  wire             clk,
  input  wire             rst,
  input  wire             push,
  input  wire [WIDTH-1:0] push_data,
  output wire             full,
  input  wire             pop,
  output reg  [WIDTH-1:0] pop_data,
  output wire             empty
);
  localparam DEPTH = 1 << DEPTH_LOG2;

  reg [WIDTH-1:0]    mem [0:DEPTH-1];
  reg [DEPTH_LOG2:0] wr_ptr;
  reg [DEPTH_LOG2:0] rd_ptr;

  assign empty = (wr_ptr == rd_ptr);
  assign full  = (wr_ptr[DEPTH_LOG2] != rd_ptr[DEPTH_LOG2]) &&
                 (wr_ptr[DEPTH_LOG2-1:0] == rd_ptr[DEPTH_LOG2-1:0]);

  always @(posedge clk)
  begin
    if (push && !full)
      mem[wr_ptr[DEPTH_LOG2-1:0]] <= push_data;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr   <= {(DEPTH_LOG2+1){1'b0}};
      rd_ptr   <= {(DEPTH_LOG2+1){1'b0}};
      pop_data <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push && !full)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop && !empty)
      begin
        pop_data <= mem[rd_ptr[DEPTH_LOG2-1:0]];
        rd_ptr   <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// File: rtl/README_unused.v
// spare source file; it holds no logic

// File: rtl/uart_dir_defines.vh
// register offsets, field positions, reset values and timing counts
`ifndef UART_DIR_DEFINES_VH
`define UART_DIR_DEFINES_VH

`define A_DATA      3'h0
`define A_LINE      3'h1
`define A_DIV_LO    3'h2
`define A_DIV_HI    3'h3
`define A_STATUS    3'h4
`define A_MODE      3'h5

`define LINE_LEN_LO 0
`define LINE_LEN_HI 1
`define LINE_STOP   2
`define LINE_PAR_EN 3
`define LINE_EVEN   4

`define ST_RX_AVAIL 0
`define ST_TX_FULL  1
`define ST_TX_IDLE  2
`define ST_PAR_ERR  3
`define ST_FRM_ERR  4
`define ST_OVERRUN  5
`define ST_DRV_EN   6
`define ST_RCV_EN   7

`define MODE_HALF   0

`define LINE_RESET  8'h03
`define DIV_RESET   16'h0001
`define MODE_RESET  8'h01

`define PRESCALE_1X 3'h4
`define PRESCALE_4X 3'h1
`define OVERSAMPLE  5'h10
`define HALF_BIT    5'h08
`define STOP_ONE    6'h10
`define STOP_MID    6'h18
`define STOP_TWO    6'h20

`endif
